// File: shared/thalm_pkg.sv
// Package of constants for the thermal alarm outputs block
package thalm_pkg;
    // Register offsets
    localparam logic [3:0] OFS_CONFIG    = 4'h0;
    localparam logic [3:0] OFS_STATUS    = 4'h1;
    localparam logic [3:0] OFS_HYST      = 4'h2;
    localparam logic [3:0] OFS_OFFSET    = 4'h3;
    localparam logic [3:0] OFS_LOC_HIGH  = 4'h4;
    localparam logic [3:0] OFS_LOC_LOW   = 4'h5;
    localparam logic [3:0] OFS_LOC_FS    = 4'h6;
    localparam logic [3:0] OFS_REM_HIGH  = 4'h7;
    localparam logic [3:0] OFS_REM_LOW   = 4'h8;
    localparam logic [3:0] OFS_REM_FS    = 4'h9;
    localparam logic [3:0] OFS_LOC_TEMP  = 4'hA;
    localparam logic [3:0] OFS_REM_TEMP  = 4'hB;
    localparam logic [3:0] OFS_OUTPUTS   = 4'hC;
    // Configuration fields
    localparam int CFG_MASK_BIT   = 7;
    localparam int CFG_SECOND_BIT = 5;
    // Status fields
    localparam int ST_LOC_LOW_BIT  = 0;
    localparam int ST_LOC_HIGH_BIT = 1;
    localparam int ST_OPEN_BIT     = 2;
    localparam int ST_REM_LOW_BIT  = 3;
    localparam int ST_REM_HIGH_BIT = 4;
    localparam int ST_LOC_FS_BIT   = 5;
    localparam int ST_REM_FS_BIT   = 6;
    // Reset values
    localparam logic [7:0] RST_CONFIG   = 8'h00;
    localparam logic [7:0] RST_HYST     = 8'h0A;
    localparam logic [7:0] RST_OFFSET   = 8'h00;
    localparam logic [7:0] RST_LOC_HIGH = 8'h55;
    localparam logic [7:0] RST_LOC_LOW  = 8'h00;
    localparam logic [7:0] RST_LOC_FS   = 8'h55;
    localparam logic [7:0] RST_REM_HIGH = 8'h55;
    localparam logic [7:0] RST_REM_LOW  = 8'h00;
    localparam logic [7:0] RST_REM_FS   = 8'h55;
endpackage

// File: rtl/thalm_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module thalm_sync
    import thalm_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // First stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// File: rtl/thalm_hyst.sv
// Comparator with hysteresis release for one fail-safe channel
`timescale 1ns/1ps
module thalm_hyst
    import thalm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              eval,
    input  wire logic signed [9:0] temp,
    input  wire logic signed [7:0] limit,
    input  wire logic        [7:0] hyst,
    output logic                   active
);
    logic signed [9:0] lim_ext;
    logic signed [9:0] rel_lvl;
    logic              trip;
    logic              release_ok;

    // Release level is limit minus hysteresis, widened to avoid wrap
    assign lim_ext    = 10'(limit);
    assign rel_lvl    = lim_ext - $signed({2'b00, hyst});
    assign trip       = temp > lim_ext;
    assign release_ok = temp <= rel_lvl;

    // Set above limit, clear by itself at limit minus hysteresis
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
        end else if (eval) begin
            if (trip) begin
                active <= 1'b1;
            end else if (release_ok) begin
                active <= 1'b0;
            end
        end
    end
endmodule

// File: rtl/thalm_top.sv
// Alarm, fail-safe and open-fault logic of a two-channel temperature monitor
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// RL1 - Open-circuit comparator is sampled only when a conversion starts.
// RL2 - Detected open circuit sets status bit 2.
// RL3 - In alarm mode a set open flag drives the alarm low.
// RL4 - Alarm asserts above high limit or at/below low limit, either channel.
// RL5 - Alarm is maskable; primary fail-safe output has no mask.
// RL6 - Alarm releases after address read, status clear and cause gone.
// RL7 - Fail-safe output low when either channel exceeds its fail-safe limit.
// RL8 - Fail-safe output releases itself at limit minus hysteresis.
// RL9 - Hysteresis resets to ten degrees and is rewritable anytime.
// RL10 - Hysteresis is an unsigned eight-bit count of whole degrees.
// RL11 - Shared pin is either the limit alarm or a second fail-safe.
// RL12 - Second fail-safe goes low above high limit, unmaskable.
// RL13 - Second fail-safe releases with the same hysteresis.
// RL14 - Signed offset register is added to every measured result.
// RL15 - Host reads alert response address; alarming device returns its address. Here ARA_READ only marks the service; no address is returned.
// RL16 - All comparisons are re-evaluated on every new conversion result.
module thalm_top
    import thalm_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       CONV_START,
    input  wire logic       OPEN_CMP,
    input  wire logic       LOC_VALID,
    input  wire logic [7:0] LOC_RAW,
    input  wire logic       REM_VALID,
    input  wire logic [7:0] REM_RAW,
    input  wire logic       ARA_READ,
    output logic            ALERT_SHARED_N,
    output logic            FAILSAFE_OVERTEMP_N
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers and wires

    logic       [7:0] config_q;
    logic       [7:0] hyst_q;
    logic signed [7:0] offset_q;
    logic signed [7:0] loc_high_q, loc_low_q, loc_fs_q;
    logic signed [7:0] rem_high_q, rem_low_q, rem_fs_q;
    logic signed [7:0] loc_temp_q, rem_temp_q;
    logic       [6:0] status_q;
    logic       [6:0] status_d;
    logic             alert_q;
    logic             alert_d;
    logic             ara_seen_q;
    logic             eval_q;
    logic             open_pin;
    logic             conv_pin;
    logic             conv_prev_q;
    logic       [7:0] rdata_d;
    logic             fs_loc, fs_rem, sf_loc, sf_rem;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Offset correction with saturation to the signed eight-bit range
    function automatic logic signed [7:0] corrected(input logic signed [7:0] raw,
                                                    input logic signed [7:0] ofs);
        logic signed [8:0] sum;
        sum = 9'(raw) + 9'(ofs);
        if (sum > 9'sd127) begin
            corrected = 8'sh7F;
        end else if (sum < -9'sd128) begin
            corrected = 8'sh80;
        end else begin
            corrected = sum[7:0];
        end
    endfunction

    // Pin inputs from the analog side cross two flops first
    thalm_sync #(.W(2)) u_sync (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .din   ({OPEN_CMP, CONV_START}),
        .dout  ({open_pin, conv_pin})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode and comparisons

    wire w_en       = WR;
    wire conv_rise  = conv_pin & ~conv_prev_q;
    wire mode_sec   = config_q[CFG_SECOND_BIT];
    wire alert_mask = config_q[CFG_MASK_BIT];
    wire status_clr = w_en && (ADDR == OFS_STATUS);
    wire loc_hi_ev  = loc_temp_q > loc_high_q; // RL4
    wire loc_lo_ev  = loc_temp_q <= loc_low_q; // RL4
    wire rem_hi_ev  = rem_temp_q > rem_high_q; // RL4
    wire rem_lo_ev  = rem_temp_q <= rem_low_q; // RL4
    wire cause_now  = loc_hi_ev | loc_lo_ev | rem_hi_ev | rem_lo_ev | status_q[ST_OPEN_BIT];

    // Status flags: hardware set wins over software clear
    always_comb begin
        status_d = status_clr ? 7'h00 : status_q;
        if (eval_q) begin
            status_d[ST_LOC_HIGH_BIT] = status_d[ST_LOC_HIGH_BIT] | loc_hi_ev; // RL16
            status_d[ST_LOC_LOW_BIT]  = status_d[ST_LOC_LOW_BIT] | loc_lo_ev;
            status_d[ST_REM_HIGH_BIT] = status_d[ST_REM_HIGH_BIT] | rem_hi_ev;
            status_d[ST_REM_LOW_BIT]  = status_d[ST_REM_LOW_BIT] | rem_lo_ev;
            status_d[ST_LOC_FS_BIT]   = status_d[ST_LOC_FS_BIT] | fs_loc;
            status_d[ST_REM_FS_BIT]   = status_d[ST_REM_FS_BIT] | fs_rem;
        end
        if (conv_rise && open_pin) begin
            status_d[ST_OPEN_BIT] = 1'b1; // RL1 RL2
        end
    end

    // Alarm latch: sets on any flag, released only after service and clear
    always_comb begin
        alert_d = alert_q;
        if (|status_q) begin
            alert_d = 1'b1; // RL4 RL3
        end else if (ara_seen_q && !cause_now) begin
            alert_d = 1'b0; // RL6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fail-safe comparators, both channels, shared hysteresis

    thalm_hyst u_fs_loc (
        .clk (CLK_SYS), .rst_n (RST_N), .eval (eval_q),
        .temp (10'(loc_temp_q)), .limit (loc_fs_q), .hyst (hyst_q), .active (fs_loc)
    );
    thalm_hyst u_fs_rem (
        .clk (CLK_SYS), .rst_n (RST_N), .eval (eval_q),
        .temp (10'(rem_temp_q)), .limit (rem_fs_q), .hyst (hyst_q), .active (fs_rem)
    );
    thalm_hyst u_sf_loc (
        .clk (CLK_SYS), .rst_n (RST_N), .eval (eval_q),
        .temp (10'(loc_temp_q)), .limit (loc_high_q), .hyst (hyst_q), .active (sf_loc)
    );
    thalm_hyst u_sf_rem (
        .clk (CLK_SYS), .rst_n (RST_N), .eval (eval_q),
        .temp (10'(rem_temp_q)), .limit (rem_high_q), .hyst (hyst_q), .active (sf_rem)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped offsets read as zero

    always_comb begin
        unique case (ADDR)
            OFS_CONFIG:   rdata_d = config_q;
            OFS_STATUS:   rdata_d = {1'b0, status_q};
            OFS_HYST:     rdata_d = hyst_q;
            OFS_OFFSET:   rdata_d = offset_q;
            OFS_LOC_HIGH: rdata_d = loc_high_q;
            OFS_LOC_LOW:  rdata_d = loc_low_q;
            OFS_LOC_FS:   rdata_d = loc_fs_q;
            OFS_REM_HIGH: rdata_d = rem_high_q;
            OFS_REM_LOW:  rdata_d = rem_low_q;
            OFS_REM_FS:   rdata_d = rem_fs_q;
            OFS_LOC_TEMP: rdata_d = loc_temp_q;
            OFS_REM_TEMP: rdata_d = rem_temp_q;
            OFS_OUTPUTS:  rdata_d = {5'h00, alert_q, fs_loc | fs_rem, sf_loc | sf_rem};
            default:      rdata_d = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written registers

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            config_q   <= RST_CONFIG;
            hyst_q     <= RST_HYST; // RL9
            offset_q   <= RST_OFFSET;
            loc_high_q <= RST_LOC_HIGH;
            loc_low_q  <= RST_LOC_LOW;
            loc_fs_q   <= RST_LOC_FS;
            rem_high_q <= RST_REM_HIGH;
            rem_low_q  <= RST_REM_LOW;
            rem_fs_q   <= RST_REM_FS;
        end else if (w_en) begin
            unique case (ADDR)
                OFS_CONFIG:   config_q   <= WDATA; // RL11
                OFS_HYST:     hyst_q     <= WDATA; // RL9 RL10
                OFS_OFFSET:   offset_q   <= WDATA;
                OFS_LOC_HIGH: loc_high_q <= WDATA;
                OFS_LOC_LOW:  loc_low_q  <= WDATA;
                OFS_LOC_FS:   loc_fs_q   <= WDATA;
                OFS_REM_HIGH: rem_high_q <= WDATA;
                OFS_REM_LOW:  rem_low_q  <= WDATA;
                OFS_REM_FS:   rem_fs_q   <= WDATA;
                default:      ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Results, evaluation strobe and alarm state

    // A limit write also re-evaluates, so new limits act on held results
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            loc_temp_q  <= 8'h00;
            rem_temp_q  <= 8'h00;
            eval_q      <= 1'b0;
            conv_prev_q <= 1'b0;
            status_q    <= 7'h00;
            alert_q     <= 1'b0;
            ara_seen_q  <= 1'b0;
        end else begin
            if (LOC_VALID) begin
                loc_temp_q <= corrected(LOC_RAW, offset_q); // RL14
            end
            if (REM_VALID) begin
                rem_temp_q <= corrected(REM_RAW, offset_q); // RL14
            end
            eval_q      <= LOC_VALID | REM_VALID | (w_en && ADDR != OFS_STATUS); // RL16
            conv_prev_q <= conv_pin;
            status_q    <= status_d;
            alert_q     <= alert_d;
            // Service is remembered until the alarm actually releases
            if (ARA_READ && alert_q) begin
                ara_seen_q <= 1'b1; // RL15
            end else if (!alert_d) begin
                ara_seen_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            RDATA               <= 8'h00;
            ALERT_SHARED_N      <= 1'b1;
            FAILSAFE_OVERTEMP_N <= 1'b1;
        end else begin
            RDATA               <= RD ? rdata_d : 8'h00;
            FAILSAFE_OVERTEMP_N <= ~(fs_loc | fs_rem); // RL5 RL7 RL8
            if (mode_sec) begin
                ALERT_SHARED_N <= ~(sf_loc | sf_rem); // RL11 RL12 RL13
            end else begin
                ALERT_SHARED_N <= ~(alert_q & ~alert_mask); // RL3 RL5
            end
        end
    end
endmodule

// File: dv/thalm_host.sv
// Behavioural model of the bus host that services the shared alarm line
`timescale 1ns/1ps
module thalm_host (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic alert_n,
    input  wire logic service,
    output logic      ara_read
);
    // Alert response read goes out only while the shared line is pulled low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ara_read <= 1'b0;
        end else begin
            ara_read <= service && !alert_n;
        end
    end
endmodule

// File: dv/thalm_assertions.sv
// Checker of the shared alarm and fail-safe pin behaviour
`timescale 1ns/1ps
module thalm_chk
    import thalm_pkg::*;
(
    input wire logic       CLK_SYS,
    input wire logic       RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       CONV_START,
    input wire logic       LOC_VALID,
    input wire logic       REM_VALID,
    input wire logic       ARA_READ,
    input wire logic       ALERT_SHARED_N,
    input wire logic       FAILSAFE_OVERTEMP_N
);
    logic [7:0] hyst_q;
    logic       mask_q;
    logic       second_q;
    logic [3:0] ev_q;
    logic [3:0] ara_q;
    logic [3:0] cfw_q;
    logic [3:0] sclr_q;
    wire        cfg_wr = WR && (ADDR == OFS_CONFIG);
    wire        st_wr  = WR && (ADDR == OFS_STATUS);
    wire        ev     = LOC_VALID || REM_VALID || WR || CONV_START;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////////////////
    // Shadow settings and ages of the last causes; ages saturate so stale causes read 15
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            hyst_q   <= RST_HYST;
            mask_q   <= RST_CONFIG[CFG_MASK_BIT];
            second_q <= RST_CONFIG[CFG_SECOND_BIT];
            ev_q     <= 4'hF;
            ara_q    <= 4'hF;
            cfw_q    <= 4'hF;
            sclr_q   <= 4'hF;
        end else begin
            hyst_q   <= (WR && ADDR == OFS_HYST) ? WDATA : hyst_q;
            mask_q   <= cfg_wr ? WDATA[CFG_MASK_BIT] : mask_q;
            second_q <= cfg_wr ? WDATA[CFG_SECOND_BIT] : second_q;
            ev_q     <= ev ? 4'h0 : ev_q + {3'h0, ev_q != 4'hF};
            ara_q    <= ARA_READ ? 4'h0 : ara_q + {3'h0, ara_q != 4'hF};
            cfw_q    <= cfg_wr ? 4'h0 : cfw_q + {3'h0, cfw_q != 4'hF};
            // Status clear may be the last of the two service steps
            sclr_q   <= st_wr ? 4'h0 : sclr_q + {3'h0, sclr_q != 4'hF};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////
    // Pins may only move shortly after something that forces a re-evaluation or, for the alarm release, a service
    AST_HYST_READ: assert property ($past(RD) && $past(ADDR) == OFS_HYST
        |-> RDATA == $past(hyst_q)) else $error("hysteresis read back differs");
    AST_FS_FALL: assert property ($fell(FAILSAFE_OVERTEMP_N) |-> ev_q <= 4'h8)
        else $error("fail-safe fell with no new result");
    AST_FS_RISE: assert property ($rose(FAILSAFE_OVERTEMP_N) |-> $past(ev_q) <= 4'h7)
        else $error("fail-safe rose with no new result");
    AST_ALERT_FALL: assert property ($fell(ALERT_SHARED_N) |-> ev_q <= 4'h9)
        else $error("alarm fell with no cause");
    AST_ALERT_RELEASE: assert property ($rose(ALERT_SHARED_N) && !second_q
        |-> ara_q <= 4'h5 || sclr_q <= 4'h5 || cfw_q <= 4'h5)
        else $error("alarm released without service");
    AST_ALERT_HOLD: assert property (!second_q && !ALERT_SHARED_N && ara_q > 4'h5
        && sclr_q > 4'h5 && cfw_q > 4'h5 |=> !ALERT_SHARED_N)
        else $error("alarm dropped by itself");
    AST_ALERT_MASKED: assert property (mask_q && !second_q && cfw_q > 4'h3
        |-> ALERT_SHARED_N) else $error("masked alarm drove the pin");
    AST_SECOND_CAUSE: assert property (second_q && cfw_q > 4'h5
        && $changed(ALERT_SHARED_N) |-> ev_q <= 4'h9) else $error("second output moved alone");
endmodule
bind thalm_top thalm_chk u_chk (
    .CLK_SYS, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .CONV_START, .LOC_VALID,
    .REM_VALID, .ARA_READ, .ALERT_SHARED_N, .FAILSAFE_OVERTEMP_N
);

// File: dv/thalm_top_tb.sv
// Self-checking bench of the thermal alarm outputs block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module thalm_top_tb
    import thalm_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] raw = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       conv = 1'b0;
    logic       open_cmp = 1'b0;
    logic       loc_v = 1'b0;
    logic       rem_v = 1'b0;
    logic       service = 1'b0;
    logic [7:0] rdata;
    logic [7:0] v;
    logic       ara;
    logic       alert_n;
    logic       fs_n;
    int         num_errors = 0;
    int         n_compared = 0;
    always #12.5 clk = ~clk;
    thalm_top dut (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .CONV_START(conv), .OPEN_CMP(open_cmp), .LOC_VALID(loc_v),
        .LOC_RAW(raw), .REM_VALID(rem_v), .REM_RAW(raw), .ARA_READ(ara),
        .ALERT_SHARED_N(alert_n), .FAILSAFE_OVERTEMP_N(fs_n));
    thalm_host host (.clk(clk), .rst_n(rst_n), .alert_n(alert_n), .service(service),
        .ara_read(ara));
    ////////////////////////////////////////////////////////////////////////////////////
    // Register bus: one-cycle strobes, read data taken in the cycle after the strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // One result on a channel, then time for the whole pipe to reach the pins
    task automatic result(input logic rem, input logic [7:0] t);
        @(posedge clk);
        loc_v <= !rem;
        rem_v <= rem;
        raw <= t;
        @(posedge clk);
        loc_v <= 1'b0;
        rem_v <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic conv_pulse();
        @(posedge clk);
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask
    // Host service: the model only answers while the line is low
    task automatic ara_cycle();
        @(posedge clk);
        service <= 1'b1;
        @(posedge clk);
        service <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Quiet temperatures, cleared status and a service leave the alarm released
    task automatic calm();
        result(1'b0, 8'h28);
        result(1'b1, 8'h28);
        wr_reg(OFS_STATUS, 8'h00);
        ara_cycle();
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd_reg(OFS_HYST, v);
        `CHK("hyst reset", RST_HYST, v)
        wr_reg(OFS_HYST, 8'h01);
        rd_reg(OFS_HYST, v);
        `CHK("hyst one", 8'h01, v)
        wr_reg(OFS_HYST, 8'h0A);
        rd_reg(4'hF, v);
        `CHK("unmapped", 8'h00, v)
    endtask
    task automatic t_failsafe();
        calm();
        wr_reg(OFS_LOC_FS, 8'h50);
        wr_reg(OFS_REM_FS, 8'h50);
        result(1'b0, 8'h51);
        `CHK("fs local", 1'b0, fs_n)
        result(1'b0, 8'h47);
        `CHK("fs hold", 1'b0, fs_n)
        result(1'b0, 8'h46);
        `CHK("fs release", 1'b1, fs_n)
        result(1'b1, 8'h51);
        `CHK("fs remote", 1'b0, fs_n)
        result(1'b1, 8'h46);
        `CHK("fs rem release", 1'b1, fs_n)
        wr_reg(OFS_OFFSET, 8'hFB);
        result(1'b0, 8'h54);
        `CHK("fs offset", 1'b1, fs_n)
        rd_reg(OFS_LOC_TEMP, v);
        `CHK("corrected", 8'h4F, v)
        wr_reg(OFS_OFFSET, 8'h00);
    endtask
    task automatic t_alert();
        calm();
        result(1'b1, 8'h56);
        `CHK("alarm high", 1'b0, alert_n)
        result(1'b1, 8'h28);
        ara_cycle();
        `CHK("alarm needs clear", 1'b0, alert_n)
        wr_reg(OFS_STATUS, 8'h00);
        ara_cycle();
        `CHK("alarm released", 1'b1, alert_n)
        result(1'b0, 8'h00);
        `CHK("alarm low equal", 1'b0, alert_n)
    endtask
    task automatic t_open();
        calm();
        open_cmp <= 1'b1;
        result(1'b1, 8'h28);
        rd_reg(OFS_STATUS, v);
        `CHK("open unsampled", 1'b0, v[ST_OPEN_BIT])
        conv_pulse();
        rd_reg(OFS_STATUS, v);
        `CHK("open flag", 1'b1, v[ST_OPEN_BIT])
        `CHK("open alarm", 1'b0, alert_n)
        open_cmp <= 1'b0;
        conv_pulse();
    endtask
    task automatic t_mask();
        calm();
        wr_reg(OFS_CONFIG, 8'h80);
        result(1'b0, 8'h5A);
        `CHK("masked alarm", 1'b1, alert_n)
        `CHK("unmasked fs", 1'b0, fs_n)
        wr_reg(OFS_CONFIG, 8'h00);
    endtask
    task automatic t_second();
        calm();
        wr_reg(OFS_CONFIG, 8'hA0);
        result(1'b1, 8'h56);
        `CHK("second set", 1'b0, alert_n)
        result(1'b1, 8'h4C);
        `CHK("second hold", 1'b0, alert_n)
        result(1'b1, 8'h4B);
        `CHK("second release", 1'b1, alert_n)
        wr_reg(OFS_CONFIG, 8'h00);
        calm();
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_failsafe();
        t_alert();
        t_open();
        t_mask();
        t_second();
        summarize();
    end
    // Whole run is well under two thousand cycles; a hang ends as a failure
    initial begin
        #(25 * 6000);
        num_errors++;
        summarize();
    end
endmodule
